// ---- pkg/tbus_cfg.svh ----
// Behaviour
// - Buffer data section starts at third DWORD, after command words A and B.
// - Start offset bits 1:0 pick first valid byte lane of first data DWORD.
// - Start offset bits 4:2 count up to 7 leading DWORDs, discarded.
// - Unused trailing bytes of the final DWORD are never sent to the MAC.
// - End alignment 4, 16 or 32 bytes; host pads, device drops the filler.
// - Only partial first/last and whole middle DWORDs reach the MAC.
// - At most one status word per packet, through a separate status FIFO.
// - Normal mode: transmission suspends while status FIFO full, resumes after reads.
// - Discard mode keeps transmitting with full status FIFO; stored status readable.
// - Discard overrun: used count reads zero, no pushes until host reads.
// - Discard overrun never raises the transmitter error flag.
// - Status bits 31:16 carry the packet tag from command word B.
// - Status bit 15 is OR of bits 11, 10, 9, 8, 2 and 1.
// - Bit 11 carrier lost, bit 10 no carrier during transmission.
// - Bit 9 flags late collision after the 64-byte window.
// - Bit 8 flags abort after 16 collisions.
// - Bits 6:3 give collision count; invalid when bit 8 set.
// - Bit 2 excessive deferral when checking enabled; bit 0 packet deferred.
// - Running buffer size sum differing from packet length sets error flag.
// - Command A bit 13 marks first segment, bit 12 last segment.
`ifndef TBUS_CFG_SVH
`define TBUS_CFG_SVH

// Register byte addresses
`define TBUS_ADDR_DATA    4'h0
`define TBUS_ADDR_STATUS  4'h4
`define TBUS_ADDR_CFG     4'h8
`define TBUS_ADDR_INFO    4'hC

// Configuration and info bits
`define TBUS_CFG_DISCARD  0
`define TBUS_CFG_DEFCHK   1
`define TBUS_INFO_TXE     31
`define TBUS_INFO_LOCK    30

// Command word A fields
`define TBUS_CA_SIZE_MSB  10
`define TBUS_CA_LAST      12
`define TBUS_CA_FIRST     13
`define TBUS_CA_OFF_LSB   16
`define TBUS_CA_OFF_MSB   20
`define TBUS_CA_ALN_LSB   24
`define TBUS_CA_ALN_MSB   25

// Command word B fields
`define TBUS_CB_LEN_MSB   10
`define TBUS_CB_TAG_LSB   16

// End alignment codes and word masks
`define TBUS_ALN_16       2'h1
`define TBUS_ALN_32       2'h2
`define TBUS_MASK_4       12'h000
`define TBUS_MASK_16      12'h003
`define TBUS_MASK_32      12'h007

// Status word fields
`define TBUS_ST_TAG_LSB   16
`define TBUS_ST_ES        15
`define TBUS_ST_LOSS      11
`define TBUS_ST_NOCAR     10
`define TBUS_ST_LATE      9
`define TBUS_ST_EXCOL     8
`define TBUS_ST_CCNT_LSB  3
`define TBUS_ST_EXDEF     2
`define TBUS_ST_RSV1      1
`define TBUS_ST_DEFER     0

`endif

// ---- pkg/tbus_pkg.sv ----
`default_nettype none
package tbus_pkg;
  // Buffer unpacker phases
  typedef enum logic [1:0] {
    TBUS_ST_CMD_A = 2'b00,
    TBUS_ST_CMD_B = 2'b01,
    TBUS_ST_BODY  = 2'b10
  } tbus_state_t;
endpackage
`default_nettype wire

// ---- src/tbus_top.sv ----
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "tbus_cfg.svh"

module tbus_top #(
  parameter int SFIFO_DEPTH = 16,
  parameter int SFIFO_AW    = 4
) (
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic      [7:0]  o_mac_data,
  output logic             o_mac_valid,
  output logic             o_mac_last,
  input  wire logic        i_mac_ready,
  input  wire logic        i_txres_valid,
  input  wire logic        i_txres_loss_carrier,
  input  wire logic        i_txres_no_carrier,
  input  wire logic        i_txres_late_coll,
  input  wire logic        i_txres_excess_coll,
  input  wire logic [3:0]  i_txres_coll_count,
  input  wire logic        i_txres_excess_defer,
  input  wire logic        i_txres_deferred,
  output logic             o_transmitter_error_flag
);

  localparam logic [SFIFO_AW:0] DEPTH_C = (SFIFO_AW + 1)'(SFIFO_DEPTH);

  tbus_pkg::tbus_state_t state_r;
  logic                  wait_r;
  logic [31:0]           rdata_r;
  logic [1:0]            cfg_r;
  logic [4:0]            off_r;
  logic [1:0]            aln_r;
  logic [10:0]           size_r;
  logic                  first_segment_flag_r;
  logic                  last_seg_r;
  logic [31:0]           cmd_b_r;
  logic [11:0]           sum_r;
  logic [11:0]           idx_r;
  logic                  txe_r;
  logic [31:0]           word_r;
  logic [1:0]            lane_r;
  logic [1:0]            end_r;
  logic                  is_last_r;
  logic                  ser_busy_r;
  logic [7:0]            mdata_r;
  logic                  mvalid_r;
  logic                  mlast_r;
  logic                  tx_active_r;
  logic                  wait_result_r;
  logic [15:0]           done_tag_r;
  logic [31:0]           smem [SFIFO_DEPTH];
  logic [SFIFO_AW-1:0]   swp_r;
  logic [SFIFO_AW-1:0]   srp_r;
  logic [SFIFO_AW:0]     status_fifo_used_count;
  logic                  lock_r;

  // Buffer geometry from the captured command word A
  logic [11:0] span;
  logic [11:0] data_dw;
  logic [11:0] off_dw;
  logic [11:0] lead;
  logic [11:0] mask;
  logic [11:0] total;
  logic [11:0] di;
  logic        is_data;
  logic [1:0]  end_lane;
  always_comb begin
    span    = {1'b0, size_r} + {10'h000, off_r[1:0]};
    data_dw = (span + 12'h003) >> 2;
    off_dw  = {9'h000, off_r[4:2]};
    lead    = off_dw + data_dw;
    if (aln_r == `TBUS_ALN_16) begin
      mask = `TBUS_MASK_16;
    end else if (aln_r == `TBUS_ALN_32) begin
      mask = `TBUS_MASK_32;
    end else begin
      mask = `TBUS_MASK_4;
    end
    total    = (lead + mask) & ~mask;
    di       = idx_r - off_dw;
    is_data  = (idx_r >= off_dw) && (idx_r < lead);
    end_lane = 2'(span - 12'h001);
  end

  // Bus request classification; a data word waits while the serialiser
  // still holds the previous one, which is the back-pressure to the host
  logic at_data;
  logic at_status;
  logic at_cfg;
  logic at_info;
  logic blocked;
  logic take;
  logic take_rd;
  logic take_wr;
  logic wr_data;
  logic pop;
  always_comb begin
    at_data   = (i_avs_address == `TBUS_ADDR_DATA);
    at_status = (i_avs_address == `TBUS_ADDR_STATUS);
    at_cfg    = (i_avs_address == `TBUS_ADDR_CFG);
    at_info   = (i_avs_address == `TBUS_ADDR_INFO);
    blocked   = at_data && (state_r == tbus_pkg::TBUS_ST_BODY)
                && is_data && ser_busy_r;
    take_rd   = wait_r && i_avs_read;
    take_wr   = wait_r && i_avs_write && !i_avs_read && !blocked;
    take      = take_rd || take_wr;
    wr_data   = take_wr && at_data;
    pop       = take_rd && at_status && (status_fifo_used_count != '0);
  end

  // Waitrequest drops for exactly the one cycle after a request is taken
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !take;
    end
  end

  // Read data mux; unmapped addresses and an empty status FIFO read zero
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (take_rd) begin
      if (at_status) begin
        rdata_r <= pop ? smem[srp_r] : 32'h0000_0000;
      end else if (at_cfg) begin
        rdata_r <= {30'h0000_0000, cfg_r};
      end else if (at_info) begin
        rdata_r <= 32'h0000_0000;
        rdata_r[`TBUS_INFO_TXE]  <= txe_r;
        rdata_r[`TBUS_INFO_LOCK] <= lock_r;
        rdata_r[15:0] <= lock_r ? 16'h0000
                                : 16'(status_fifo_used_count);
      end else begin
        rdata_r <= 32'h0000_0000;
      end
    end
  end

  // Configuration register: discard mode and deferral checking
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_r <= 2'h0;
    end else if (take_wr && at_cfg && i_avs_byteenable[0]) begin
      cfg_r <= i_avs_writedata[1:0];
    end
  end

  // Unpacker: command A, command B, then offset, data and filler words
  logic       start_pkt;
  logic [11:0] seg_sum;
  always_comb begin
    seg_sum = (first_segment_flag_r ? 12'h000 : sum_r) + {1'b0, size_r};
  end
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r              <= tbus_pkg::TBUS_ST_CMD_A;
      off_r                <= 5'h00;
      aln_r                <= 2'h0;
      size_r               <= 11'h000;
      first_segment_flag_r <= 1'b0;
      last_seg_r           <= 1'b0;
      cmd_b_r              <= 32'h0000_0000;
      sum_r                <= 12'h000;
      idx_r                <= 12'h000;
    end else if (wr_data) begin
      case (state_r)
        tbus_pkg::TBUS_ST_CMD_A: begin
          off_r  <= i_avs_writedata[`TBUS_CA_OFF_MSB:`TBUS_CA_OFF_LSB];
          aln_r  <= i_avs_writedata[`TBUS_CA_ALN_MSB:`TBUS_CA_ALN_LSB];
          size_r <= i_avs_writedata[`TBUS_CA_SIZE_MSB:0];
          first_segment_flag_r <= i_avs_writedata[`TBUS_CA_FIRST];
          last_seg_r <= i_avs_writedata[`TBUS_CA_LAST];
          state_r    <= tbus_pkg::TBUS_ST_CMD_B;
        end
        tbus_pkg::TBUS_ST_CMD_B: begin
          cmd_b_r <= i_avs_writedata;
          sum_r   <= seg_sum;
          idx_r   <= 12'h000;
          state_r <= (total == 12'h000) ? tbus_pkg::TBUS_ST_CMD_A
                                        : tbus_pkg::TBUS_ST_BODY;
        end
        tbus_pkg::TBUS_ST_BODY: begin
          idx_r <= idx_r + 12'h001;
          if (idx_r == total - 12'h001) begin
            state_r <= tbus_pkg::TBUS_ST_CMD_A;
          end
        end
        default: begin
          state_r <= tbus_pkg::TBUS_ST_CMD_A;
        end
      endcase
    end
  end

  // Serialiser load: only data words enter; offset and filler are dropped
  logic load;
  logic emit;
  logic gate;
  always_comb begin
    load = wr_data && (state_r == tbus_pkg::TBUS_ST_BODY) && is_data;
    // In normal mode hold a new packet back while its status could not be stored, and
    // in both modes while the previous packet still awaits its result
    gate = !tx_active_r && (wait_result_r || (!cfg_r[`TBUS_CFG_DISCARD]
           && (status_fifo_used_count == DEPTH_C)));
    emit = ser_busy_r && !gate && (!mvalid_r || i_mac_ready);
  end

  // Word holding stage with first and last byte lanes
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      word_r     <= 32'h0000_0000;
      lane_r     <= 2'h0;
      end_r      <= 2'h0;
      is_last_r  <= 1'b0;
      ser_busy_r <= 1'b0;
    end else if (load) begin
      word_r     <= i_avs_writedata;
      lane_r     <= (di == 12'h000) ? off_r[1:0] : 2'h0;
      end_r      <= (di == data_dw - 12'h001) ? end_lane : 2'h3;
      is_last_r  <= last_seg_r && (di == data_dw - 12'h001);
      ser_busy_r <= 1'b1;
    end else if (emit) begin
      lane_r <= lane_r + 2'h1;
      if (lane_r == end_r) begin
        ser_busy_r <= 1'b0;
      end
    end
  end

  // Byte stream to the MAC transmit FIFO, registered valid/ready stage
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mdata_r  <= 8'h00;
      mvalid_r <= 1'b0;
      mlast_r  <= 1'b0;
    end else if (emit) begin
      mdata_r  <= word_r[{lane_r, 3'h0} +: 8];
      mvalid_r <= 1'b1;
      mlast_r  <= is_last_r && (lane_r == end_r);
    end else if (i_mac_ready) begin
      mvalid_r <= 1'b0;
      mlast_r  <= 1'b0;
    end
  end

  // Packet bookkeeping; the tag is kept until the MAC reports the result
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_active_r   <= 1'b0;
      wait_result_r <= 1'b0;
      done_tag_r    <= 16'h0000;
    end else begin
      if (emit) begin
        tx_active_r <= !(is_last_r && (lane_r == end_r));
        if (is_last_r && (lane_r == end_r)) begin
          wait_result_r <= 1'b1;
          done_tag_r    <= cmd_b_r[31:`TBUS_CB_TAG_LSB];
        end
      end
      if (i_txres_valid && wait_result_r) begin
        wait_result_r <= 1'b0;
      end
    end
  end

  // Status word assembly; reserved bits stay zero
  logic [31:0] sword;
  logic        push;
  logic        full;
  always_comb begin
    sword = 32'h0000_0000;
    sword[31:`TBUS_ST_TAG_LSB] = done_tag_r;
    sword[`TBUS_ST_LOSS]  = i_txres_loss_carrier;
    sword[`TBUS_ST_NOCAR] = i_txres_no_carrier;
    sword[`TBUS_ST_LATE]  = i_txres_late_coll;
    sword[`TBUS_ST_EXCOL] = i_txres_excess_coll;
    sword[`TBUS_ST_CCNT_LSB +: 4] = i_txres_coll_count;
    sword[`TBUS_ST_EXDEF] = i_txres_excess_defer
                            && cfg_r[`TBUS_CFG_DEFCHK];
    sword[`TBUS_ST_DEFER] = i_txres_deferred;
    sword[`TBUS_ST_ES] = sword[`TBUS_ST_LOSS] | sword[`TBUS_ST_NOCAR]
                       | sword[`TBUS_ST_LATE] | sword[`TBUS_ST_EXCOL]
                       | sword[`TBUS_ST_EXDEF] | sword[`TBUS_ST_RSV1];
    full = (status_fifo_used_count == DEPTH_C);
    push = i_txres_valid && wait_result_r && !full && !lock_r;
  end

  // Status FIFO storage, one word per finished packet
  always_ff @(posedge i_clock) begin
    if (push) begin
      smem[swp_r] <= sword;
    end
  end

  // Status FIFO pointers and fill count
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      swp_r <= '0;
      srp_r <= '0;
      status_fifo_used_count <= '0;
    end else begin
      if (push) begin
        swp_r <= swp_r + SFIFO_AW'(1);
      end
      if (pop) begin
        srp_r <= srp_r + SFIFO_AW'(1);
      end
      if (push && !pop) begin
        status_fifo_used_count <= status_fifo_used_count + (SFIFO_AW + 1)'(1);
      end else if (pop && !push) begin
        status_fifo_used_count <= status_fifo_used_count - (SFIFO_AW + 1)'(1);
      end
    end
  end

  // Discard-mode overrun lock; a host read of status releases it
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lock_r <= 1'b0;
    end else if (i_txres_valid && wait_result_r && full
                 && cfg_r[`TBUS_CFG_DISCARD]) begin
      lock_r <= 1'b1;
    end else if (pop) begin
      lock_r <= 1'b0;
    end
  end

  // Transmitter error: length mismatch, differing command B, or a normal
  // mode status overrun; a new error wins over a same-cycle clear
  logic txe_set;
  always_comb begin
    txe_set = 1'b0;
    if (wr_data && (state_r == tbus_pkg::TBUS_ST_CMD_B)) begin
      if (!first_segment_flag_r && (i_avs_writedata != cmd_b_r)) begin
        txe_set = 1'b1;
      end
      if (last_seg_r && (seg_sum
          != {1'b0, i_avs_writedata[`TBUS_CB_LEN_MSB:0]})) begin
        txe_set = 1'b1;
      end
    end
    if (i_txres_valid && wait_result_r && full
        && !cfg_r[`TBUS_CFG_DISCARD]) begin
      txe_set = 1'b1;
    end
  end
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      txe_r <= 1'b0;
    end else if (txe_set) begin
      txe_r <= 1'b1;
    end else if (take_wr && at_info && i_avs_byteenable[3]
                 && i_avs_writedata[`TBUS_INFO_TXE]) begin
      txe_r <= 1'b0;
    end
  end

  // Outputs straight from flip-flops
  assign o_avs_readdata           = rdata_r;
  assign o_avs_waitrequest        = wait_r;
  assign o_mac_data               = mdata_r;
  assign o_mac_valid              = mvalid_r;
  assign o_mac_last               = mlast_r;
  assign o_transmitter_error_flag = txe_r;

endmodule // tbus_top
`default_nettype wire

// ---- test/tbus_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tbus_cfg.svh"

module tbus_assertions #(
  parameter int SFIFO_DEPTH = 16,
  parameter int SFIFO_AW    = 4
) (
  input wire logic        i_clock,
  input wire logic        i_arst_n,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic [7:0]  o_mac_data,
  input wire logic        o_mac_valid,
  input wire logic        o_mac_last,
  input wire logic        i_mac_ready,
  input wire logic        i_txres_valid,
  input wire logic        o_transmitter_error_flag
);
  logic pend_r;

  // Packet sent but its result not yet back; next start must wait
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_r <= 1'b0;
    end else if (o_mac_valid && i_mac_ready && o_mac_last) begin
      pend_r <= 1'b1;
    end else if (i_txres_valid) begin
      pend_r <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  // Answer cycle, then the read of the status queue
  sequence s_answer;
    $fell(o_avs_waitrequest);
  endsequence
  sequence s_stat_rd;
    s_answer ##0 ($past(i_avs_read) &&
      $past(i_avs_address) == `TBUS_ADDR_STATUS);
  endsequence

  a_answer_one_cycle: assert property (
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_answer_has_cause: assert property (
    s_answer |-> $past(i_avs_read || i_avs_write))
    else $error("answer without a request");
  a_mac_hold_stall: assert property (
    o_mac_valid && !i_mac_ready |=> o_mac_valid && $stable(o_mac_data)
      && $stable(o_mac_last))
    else $error("mac byte changed while stalled");
  a_last_needs_valid: assert property (
    o_mac_last |-> o_mac_valid)
    else $error("last marker without valid");
  a_status_es_or: assert property (
    s_stat_rd |-> o_avs_readdata[15] ==
      |{o_avs_readdata[11:8], o_avs_readdata[2:1]})
    else $error("error summary not the or of error bits");
  a_status_rsvd_zero: assert property (
    s_stat_rd |-> o_avs_readdata[14:12] == 3'h0 && !o_avs_readdata[7]
      && !o_avs_readdata[1])
    else $error("reserved status bits not zero");
  a_unmapped_zero: assert property (
    s_answer ##0 ($past(i_avs_read) && $past(i_avs_address[1:0]) != 2'h0)
      |-> o_avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_pkt_await_result: assert property (
    pend_r |-> !o_mac_valid)
    else $error("new packet before previous result");
  a_err_clear_cause: assert property (
    $fell(o_transmitter_error_flag) |-> $past(i_avs_write &&
      i_avs_address == `TBUS_ADDR_INFO && i_avs_byteenable[3] &&
      i_avs_writedata[31]))
    else $error("error flag cleared without a clear write");
endmodule // tbus_assertions

bind tbus_top tbus_assertions #(
  .SFIFO_DEPTH(SFIFO_DEPTH), .SFIFO_AW(SFIFO_AW)) u_chk (
  .i_clock(i_clock), .i_arst_n(i_arst_n), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_mac_data(o_mac_data), .o_mac_valid(o_mac_valid),
  .o_mac_last(o_mac_last), .i_mac_ready(i_mac_ready),
  .i_txres_valid(i_txres_valid),
  .o_transmitter_error_flag(o_transmitter_error_flag));
`default_nettype wire

// ---- test/tbus_mac_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module tbus_mac_model (
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic       i_valid,
  input  wire logic       i_last,
  input  wire logic       i_slow,
  input  wire logic [9:0] i_flags,
  output logic            o_ready,
  output logic            o_res_valid,
  output logic      [9:0] o_flags
);
  logic [2:0] wait_r;

  // Ready alternates when slow so the byte stream sees backpressure
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ready <= 1'b0;
    end else begin
      o_ready <= i_slow ? ~o_ready : 1'b1;
    end
  end

  // Result comes a few cycles after the final byte, as a line would
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_r      <= 3'h0;
      o_res_valid <= 1'b0;
    end else begin
      o_res_valid <= (wait_r == 3'h1);
      if (i_valid && o_ready && i_last) begin
        wait_r <= 3'h5;
      end else if (wait_r != 3'h0) begin
        wait_r <= wait_r - 3'h1;
      end
    end
  end

  // Fields mean nothing outside the pulse, so show inverted junk there
  assign o_flags = o_res_valid ? i_flags : ~i_flags;
endmodule // tbus_mac_model
`default_nettype wire

// ---- test/test_tbus_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tbus_cfg.svh"

module test_tbus_top;
  localparam logic [3:0] A_DATA = `TBUS_ADDR_DATA;
  localparam logic [3:0] A_ST   = `TBUS_ADDR_STATUS;
  localparam logic [3:0] A_CFG  = `TBUS_ADDR_CFG;
  localparam logic [3:0] A_INFO = `TBUS_ADDR_INFO;
  logic        i_clock  = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [3:0]  av_addr  = 4'h0;
  logic        av_rd    = 1'b0;
  logic        av_wr    = 1'b0;
  logic [31:0] av_wd    = 32'h0000_0000;
  logic [3:0]  av_be    = 4'hF;
  logic        slow     = 1'b0;
  logic [9:0]  tb_flags = 10'h000;
  logic [31:0] rdata;
  logic [31:0] scratch;
  logic [7:0]  mdata;
  logic [9:0]  rflags;
  logic        wreq, mvalid, mlast, mready, rvalid, transmitter_error_flag;
  logic [15:0] tg;
  logic [9:0]  fl [6] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h03E,
                          10'h003};
  logic [8:0]  exp_q [$];
  int          err_total = 0;
  int          compares  = 0;
  int          res_cnt   = 0;
  int          mac_cnt   = 0;
  int          n;

  always #5 i_clock = ~i_clock;

  tbus_top #(.SFIFO_DEPTH(2), .SFIFO_AW(1)) dut (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_avs_address(av_addr),
    .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd),
    .i_avs_byteenable(av_be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_mac_data(mdata), .o_mac_valid(mvalid),
    .o_mac_last(mlast), .i_mac_ready(mready), .i_txres_valid(rvalid),
    .i_txres_loss_carrier(rflags[9]), .i_txres_no_carrier(rflags[8]),
    .i_txres_late_coll(rflags[7]), .i_txres_excess_coll(rflags[6]),
    .i_txres_coll_count(rflags[5:2]), .i_txres_excess_defer(rflags[1]),
    .i_txres_deferred(rflags[0]), .o_transmitter_error_flag(transmitter_error_flag));

  tbus_mac_model u_mac (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_valid(mvalid),
    .i_last(mlast), .i_slow(slow), .i_flags(tb_flags), .o_ready(mready),
    .o_res_valid(rvalid), .o_flags(rflags));

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One bus cycle; the request holds until waitrequest is seen low
  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d, input logic [3:0] be,
                    output logic [31:0] rd);
    int t;
    t = 0;
    @(posedge i_clock);
    av_addr <= a;
    av_wd   <= d;
    av_be   <= be;
    av_wr   <= wr;
    av_rd   <= ~wr;
    do begin
      @(posedge i_clock);
      t++;
    end while (wreq !== 1'b0 && t < 5000);
    rd = rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    if (t >= 5000) chk("bus answer", 32'h0000_0001, 32'h0000_0000);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    av(1'b1, a, d, 4'hF, x);
  endtask

  task automatic rdc(input string what, input logic [3:0] a,
                     input logic [31:0] e);
    logic [31:0] x;
    av(1'b0, a, 32'h0000_0000, 4'hF, x);
    chk(what, e, x);
  endtask

  // Buffer bytes carry their position so stray filler shows up
  task automatic send_buf(input logic fs, input logic ls, input int off,
                          input int size, input logic [1:0] aln,
                          input logic [15:0] tag, input int len);
    int nw, am;
    logic [31:0] w;
    am = (aln == 2'h1) ? 4 : (aln == 2'h2) ? 8 : 1;
    nw = (off + size + 3) / 4;
    nw = ((nw + am - 1) / am) * am;
    for (int k = off; k < off + size; k++)
      exp_q.push_back({ls && (k == off + size - 1), 8'(k) ^ tag[7:0]});
    wr(A_DATA, {6'h0, aln, 3'h0, 5'(off), 2'h0, fs, ls, 1'b0, 11'(size)});
    wr(A_DATA, {tag, 5'h0, 11'(len)});
    for (int i = 0; i < nw; i++) begin
      for (int j = 0; j < 4; j++) w[8*j +: 8] = 8'(4*i + j) ^ tag[7:0];
      wr(A_DATA, w);
    end
  endtask

  task automatic wait_res(input int cnt);
    int t;
    t = 0;
    while (res_cnt < cnt && t < 5000) begin
      @(posedge i_clock);
      t++;
    end
    @(posedge i_clock);
    if (t >= 5000) chk("result wait", 32'h0000_0001, 32'h0000_0000);
  endtask

  function automatic logic [31:0] st_exp(input logic [15:0] tag,
                                         input logic [9:0] f,
                                         input logic dc);
    logic xd;
    xd = f[1] & dc;
    return {tag, |{f[9:6], xd}, 3'h0, f[9:6], 1'b0, f[5:2], xd, 1'b0,
            f[0]};
  endfunction

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Every byte the MAC takes is checked against the expected stream
  always @(posedge i_clock) begin
    if (mvalid === 1'b1 && mready === 1'b1) begin
      mac_cnt++;
      chk("mac byte", exp_q.size() > 0 ? {23'h0, exp_q.pop_front()} :
          32'hFFFF_FFFF, {23'h0, mlast, mdata});
    end
    if (rvalid === 1'b1) res_cnt++;
  end

  // Watchdog: the whole run needs far fewer cycles than this
  initial begin
    repeat (60000) @(posedge i_clock);
    err_total++;
    $display("BAD watchdog expected end seen hang");
    finish_test();
  end

  initial begin
    repeat (3) @(posedge i_clock);
    i_arst_n <= 1'b1;
    rdc("cfg", A_CFG, 32'h0000_0000);
    rdc("info", A_INFO, 32'h0000_0000);
    rdc("empty status", A_ST, 32'h0000_0000);
    rdc("unmapped", 4'h6, 32'h0000_0000);
    wr(4'h6, 32'hFFFF_FFFF);
    rdc("cfg", A_CFG, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      tg = 16'hA000 + 16'(i);
      wr(A_CFG, {30'h0, i[0], 1'b0});
      slow     <= i[0];
      tb_flags <= fl[i];
      send_buf(1'b1, 1'b1, i*5, 3+i*3, 2'(i%3), tg, 3+i*3);
      wait_res(i + 1);
      rdc("status", A_ST, st_exp(tg, fl[i], i[0]));
    end
    rdc("info", A_INFO, 32'h0000_0000);
    $display("test status fields done");
    tb_flags <= 10'h000;
    send_buf(1'b1, 1'b0, 3, 3, 2'h0, 16'h0B0B, 9);
    send_buf(1'b0, 1'b0, 0, 5, 2'h2, 16'h0B0B, 9);
    send_buf(1'b0, 1'b1, 1, 1, 2'h1, 16'h0B0B, 9);
    wait_res(7);
    rdc("status", A_ST, st_exp(16'h0B0B, 10'h000, 1'b0));
    rdc("info", A_INFO, 32'h0000_0000);
    send_buf(1'b1, 1'b1, 0, 4, 2'h0, 16'h0C0C, 5);
    wait_res(8);
    rdc("info", A_INFO, 32'h8000_0001);
    chk("error flag", 32'h0000_0001, {31'h0, transmitter_error_flag});
    av(1'b1, A_INFO, 32'h8000_0000, 4'h8, scratch);
    rdc("info", A_INFO, 32'h0000_0001);
    chk("error flag", 32'h0000_0000, {31'h0, transmitter_error_flag});
    rdc("status", A_ST, st_exp(16'h0C0C, 10'h000, 1'b0));
    $display("test segments and length done");
    wr(A_CFG, 32'h0000_0000);
    slow <= 1'b0;
    send_buf(1'b1, 1'b1, 0, 4, 2'h0, 16'h0D01, 4);
    send_buf(1'b1, 1'b1, 0, 4, 2'h0, 16'h0D02, 4);
    wait_res(10);
    rdc("info", A_INFO, 32'h0000_0002);
    n = mac_cnt;
    send_buf(1'b1, 1'b1, 0, 4, 2'h0, 16'h0D03, 4);
    repeat (30) @(posedge i_clock);
    chk("bytes while full", 32'(n), 32'(mac_cnt));
    rdc("status", A_ST, st_exp(16'h0D01, 10'h000, 1'b0));
    wait_res(11);
    chk("bytes after read", 32'(n + 4), 32'(mac_cnt));
    $display("test normal full done");
    wr(A_CFG, 32'h0000_0001);
    send_buf(1'b1, 1'b1, 0, 4, 2'h0, 16'h0E01, 4);
    wait_res(12);
    rdc("info", A_INFO, 32'h4000_0000);
    rdc("status", A_ST, st_exp(16'h0D02, 10'h000, 1'b0));
    rdc("info", A_INFO, 32'h0000_0001);
    send_buf(1'b1, 1'b1, 0, 4, 2'h0, 16'h0E02, 4);
    wait_res(13);
    rdc("status", A_ST, st_exp(16'h0D03, 10'h000, 1'b0));
    rdc("status", A_ST, st_exp(16'h0E02, 10'h000, 1'b0));
    rdc("info", A_INFO, 32'h0000_0000);
    $display("test discard mode done");
    finish_test();
  end
endmodule // test_tbus_top
`default_nettype wire
